// >>> mdd_core.sv
// Matrix display driver core: serial slave, bitmap memory, display scan.
// Operation
// R1: Low reset input clears internal state
// R2: Host must pulse reset after power-up
// R3: Reset clears registers, never bitmap memory
// R4: Address pin sets slave address bit zero
// R5: Data sampled on input, ack on separate output
// R6: Host may ignore ack if unwired
// R7: Osc pin high selects on-chip oscillator
// R8: Execute command bytes, store pixel bytes
// R9: Scan reads 102-bit line, drives rows/columns
// R10: Memory is 8x102 bytes plus 102 bits
// R11: X address equals column output index
// R12: Refresh continues during bus traffic
// R13: 65 rows, 102 columns, bias from data
// R14: Host programs zero stages for external supply
// R15: Respond to addresses 0111100 or 0111101
// R16: Pixel byte committed during its ack cycle
// R17: Writes arbitrated against scan reads
// Assumes serial pins and osc pin are asynchronous to ref_clk.
`timescale 1ns/10ps
module mdd_core #(
  parameter int OSC_DIV = mdd_pkg::OSC_DIV_CYC,
  parameter int OSC_HOLD = mdd_pkg::OSC_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic panel_clk,
  input wire logic scl_in,
  input wire logic serial_data_input,
  input wire logic addr_select_pin,
  input wire logic osc_pin,
  output logic ack_output_line,
  output logic ack_output_oe,
  output logic [mdd_pkg::N_COLS-1:0] column_out,
  output logic [mdd_pkg::N_ROWS-1:0] row_out,
  output logic bias_polarity
);
  import mdd_pkg::*;

  function automatic logic filt(input logic s1, input logic s2, input logic cur);
    filt = (s1 == s2) ? s2 : cur;
  endfunction

  // Pin synchronisers
  logic [2:0] scl_s_reg, sda_s_reg, sa_s_reg, osc_s_reg, ack_s_reg;
  logic scl_f_reg, sda_f_reg, sa_f_reg, osc_f_reg, ack_f_reg;
  logic scl_f_next, sda_f_next, sa_f_next, osc_f_next, ack_f_next;
  logic scl_rise, scl_fall, i2c_start, i2c_stop, byte_evt;

  // Serial slave state
  mdd_i2c_e st_reg, st_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic in_ack_reg, in_ack_next, oe_next;
  logic co_reg, co_next, dc_reg, dc_next, vmode_reg, vmode_next;
  logic [6:0] x_reg, x_next, mem_wx_reg, mem_wx_next;
  logic [3:0] y_reg, y_next, mem_wy_reg, mem_wy_next;
  logic mem_we_reg, mem_we_next;
  logic [7:0] mem_wd_reg, mem_wd_next;

  // Scan state
  logic [15:0] hold_cnt_reg, hold_cnt_next, div_cnt_reg, div_cnt_next;
  logic int_sel_reg, int_sel_next, scan_tick;
  logic [6:0] row_reg, row_next, line_row_reg, line_row_next;
  logic pol_reg, pol_next, line_pol_reg, line_pol_next;
  logic load_req_reg, load_req_next, req_tgl_reg, req_tgl_next, busy;
  logic [N_COLS-1:0] line_reg, line_next, line_rd;
  logic ack_tgl;

  // Left without reset so contents survive a reset [R3] [R10]
  logic [7:0] bitmap_mem [N_BANKS][N_COLS];

  always_comb begin
    scl_f_next = filt(scl_s_reg[1], scl_s_reg[2], scl_f_reg);
    sda_f_next = filt(sda_s_reg[1], sda_s_reg[2], sda_f_reg);
    sa_f_next = filt(sa_s_reg[1], sa_s_reg[2], sa_f_reg);
    osc_f_next = filt(osc_s_reg[1], osc_s_reg[2], osc_f_reg);
    ack_f_next = filt(ack_s_reg[1], ack_s_reg[2], ack_f_reg);
  end

  assign scl_rise = scl_f_next & ~scl_f_reg;
  assign scl_fall = ~scl_f_next & scl_f_reg;
  assign i2c_start = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
  assign i2c_stop = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
  assign byte_evt = scl_fall & ~in_ack_reg & (bit_cnt_reg == BITS_PER_BYTE) & ~i2c_start & ~i2c_stop
                    & (st_reg != MDD_IDLE);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin // [R1]
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      sa_s_reg <= 3'h0;
      osc_s_reg <= 3'h0;
      ack_s_reg <= 3'h0;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      sa_f_reg <= 1'b0;
      osc_f_reg <= 1'b0;
      ack_f_reg <= 1'b0;
    end else begin
      // Separate data input line, sampled only [R5]
      scl_s_reg <= {scl_s_reg[1:0], scl_in};
      sda_s_reg <= {sda_s_reg[1:0], serial_data_input};
      sa_s_reg <= {sa_s_reg[1:0], addr_select_pin};
      osc_s_reg <= {osc_s_reg[1:0], osc_pin};
      ack_s_reg <= {ack_s_reg[1:0], ack_tgl};
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      sa_f_reg <= sa_f_next;
      osc_f_reg <= osc_f_next;
      ack_f_reg <= ack_f_next;
    end
  end

  always_comb begin
    st_next = st_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    in_ack_next = in_ack_reg;
    oe_next = ack_output_oe;
    co_next = co_reg;
    dc_next = dc_reg;
    vmode_next = vmode_reg;
    x_next = x_reg;
    y_next = y_reg;
    mem_we_next = 1'b0;
    mem_wd_next = mem_wd_reg;
    mem_wx_next = mem_wx_reg;
    mem_wy_next = mem_wy_reg;
    if (i2c_stop) begin
      st_next = MDD_IDLE;
      in_ack_next = 1'b0;
      oe_next = 1'b0;
    end else if (i2c_start) begin
      st_next = MDD_ADDR;
      bit_cnt_next = 4'h0;
      in_ack_next = 1'b0;
      oe_next = 1'b0;
    end else if (st_reg != MDD_IDLE) begin
      if (scl_rise && !in_ack_reg && bit_cnt_reg < BITS_PER_BYTE) begin
        shift_next = {shift_reg[6:0], sda_f_reg};
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end
      if (scl_fall && in_ack_reg) begin
        // Ack slot over: release the line [R5]
        in_ack_next = 1'b0;
        oe_next = 1'b0;
        bit_cnt_next = 4'h0;
      end else if (byte_evt) begin
        in_ack_next = 1'b1;
        case (st_reg)
          MDD_ADDR: begin
            // Reads are not served, so only write address is acknowledged
            if (shift_reg[7:1] == {SLAVE_ADDR_HI, sa_f_reg} && !shift_reg[0]) begin // [R4] [R15]
              oe_next = 1'b1;
              st_next = MDD_CTRL;
            end else begin
              st_next = MDD_SKIP;
            end
          end
          MDD_CTRL: begin
            oe_next = 1'b1;
            co_next = shift_reg[CTRL_CO_BIT];
            dc_next = shift_reg[CTRL_DC_BIT];
            st_next = MDD_DATA;
          end
          MDD_DATA: begin
            oe_next = 1'b1;
            if (dc_reg) begin
              // Write lands in the ack slot [R16] [R8]
              mem_we_next = 1'b1;
              mem_wd_next = shift_reg;
              mem_wx_next = x_reg;
              mem_wy_next = y_reg;
              if (vmode_reg) begin
                y_next = (y_reg == LAST_Y) ? 4'h0 : y_reg + 4'h1;
                if (y_reg == LAST_Y) begin
                  x_next = (x_reg == LAST_X) ? 7'h00 : x_reg + 7'h01;
                end
              end else begin
                x_next = (x_reg == LAST_X) ? 7'h00 : x_reg + 7'h01;
                if (x_reg == LAST_X) begin
                  y_next = (y_reg == LAST_Y) ? 4'h0 : y_reg + 4'h1;
                end
              end
            end else if (shift_reg[CMD_SETX_BIT]) begin // [R8]
              // Out-of-range pointers are ignored
              if (shift_reg[6:0] <= LAST_X) begin
                x_next = shift_reg[6:0];
              end
            end else if ((shift_reg & CMD_SETY_MASK) == CMD_SETY_VAL) begin
              if (shift_reg[3:0] <= LAST_Y) begin
                y_next = shift_reg[3:0];
              end
            end else if ((shift_reg & CMD_FUNC_MASK) == CMD_FUNC_VAL) begin
              vmode_next = shift_reg[FUNC_V_BIT];
            end
            if (co_reg) begin
              st_next = MDD_CTRL;
            end
          end
          default: begin
            in_ack_next = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin // [R1] [R3]
      st_reg <= MDD_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      in_ack_reg <= 1'b0;
      ack_output_oe <= 1'b0;
      ack_output_line <= 1'b0;
      co_reg <= 1'b0;
      dc_reg <= 1'b0;
      vmode_reg <= V_RST;
      x_reg <= X_RST;
      y_reg <= Y_RST;
      mem_we_reg <= 1'b0;
      mem_wd_reg <= 8'h00;
      mem_wx_reg <= X_RST;
      mem_wy_reg <= Y_RST;
    end else begin
      st_reg <= st_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      in_ack_reg <= in_ack_next;
      ack_output_oe <= oe_next;
      ack_output_line <= 1'b0;
      co_reg <= co_next;
      dc_reg <= dc_next;
      vmode_reg <= vmode_next;
      x_reg <= x_next;
      y_reg <= y_next;
      mem_we_reg <= mem_we_next;
      mem_wd_reg <= mem_wd_next;
      mem_wx_reg <= mem_wx_next;
      mem_wy_reg <= mem_wy_next;
    end
  end

  // Top bank keeps one bit per column [R10] [R11]
  always_ff @(posedge ref_clk) begin
    if (mem_we_reg) begin
      bitmap_mem[mem_wy_reg][mem_wx_reg] <= mem_wd_reg & ((mem_wy_reg == LAST_Y) ? 8'h01 : 8'hff);
    end
  end

  // Whole 102-bit line in one read, column x from address x [R9] [R11]
  always_comb begin
    for (int c = 0; c < N_COLS; c++) begin
      line_rd[c] = bitmap_mem[row_reg[6:3]][c][row_reg[2:0]];
    end
  end

  assign busy = req_tgl_reg != ack_f_reg;
  assign scan_tick = int_sel_reg ? (div_cnt_reg == 16'h0000) : (osc_f_next & ~osc_f_reg); // [R7]

  always_comb begin
    hold_cnt_next = osc_f_reg ? ((hold_cnt_reg == 16'(OSC_HOLD)) ? hold_cnt_reg : hold_cnt_reg + 16'h0001)
                              : 16'h0000;
    int_sel_next = (hold_cnt_reg == 16'(OSC_HOLD)); // [R7]
    div_cnt_next = (div_cnt_reg == 16'h0000) ? 16'(OSC_DIV - 1) : div_cnt_reg - 16'h0001;
    row_next = row_reg;
    pol_next = pol_reg;
    load_req_next = load_req_reg;
    req_tgl_next = req_tgl_reg;
    line_next = line_reg;
    line_row_next = line_row_reg;
    line_pol_next = line_pol_reg;
    // Serial writes win; the line load waits a cycle [R17]
    if (load_req_reg && !mem_we_reg && !busy) begin
      line_next = line_rd;
      line_row_next = row_reg;
      line_pol_next = pol_reg;
      req_tgl_next = ~req_tgl_reg;
      load_req_next = 1'b0;
    end
    // Scan never waits on the serial side [R12]
    if (scan_tick) begin
      row_next = (row_reg == LAST_ROW) ? 7'h00 : row_reg + 7'h01;
      if (row_reg == LAST_ROW) begin
        pol_next = ~pol_reg;
      end
      load_req_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hold_cnt_reg <= 16'h0000;
      int_sel_reg <= 1'b0;
      div_cnt_reg <= 16'h0000;
      row_reg <= 7'h00;
      pol_reg <= 1'b0;
      load_req_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      line_reg <= '0;
      line_row_reg <= 7'h00;
      line_pol_reg <= 1'b0;
    end else begin
      hold_cnt_reg <= hold_cnt_next;
      int_sel_reg <= int_sel_next;
      div_cnt_reg <= div_cnt_next;
      row_reg <= row_next;
      pol_reg <= pol_next;
      load_req_reg <= load_req_next;
      req_tgl_reg <= req_tgl_next;
      line_reg <= line_next;
      line_row_reg <= line_row_next;
      line_pol_reg <= line_pol_next;
    end
  end

  // Line word is held until the panel side acknowledges
  mdd_panel_out u_panel (
    .panel_clk(panel_clk),
    .rst_b(rst_b),
    .req_tgl(req_tgl_reg),
    .line_bits(line_reg),
    .line_row(line_row_reg),
    .line_pol(line_pol_reg),
    .ack_tgl(ack_tgl),
    .col_drive(column_out),
    .row_drive(row_out),
    .row_pol(bias_polarity)
  );

  a_reset_idle: assert property (@(posedge ref_clk) // [R1]
    !rst_b |=> st_reg == MDD_IDLE && !ack_output_oe && !mem_we_reg)
    else $error("state not cleared by reset");
  a_addr_match: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R15]
    byte_evt && st_reg == MDD_ADDR |=>
      ack_output_oe == ($past(shift_reg[7:1]) == {SLAVE_ADDR_HI, $past(sa_f_reg)} && !$past(shift_reg[0])))
    else $error("address ack mismatch");
  a_ack_release: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R5]
    ack_output_oe && scl_fall && in_ack_reg |=> !ack_output_oe && bit_cnt_reg == 4'h0)
    else $error("ack not released at end of slot");
  a_pixel_commit: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R16]
    byte_evt && st_reg == MDD_DATA && dc_reg |=> mem_we_reg && mem_wd_reg == $past(shift_reg) && in_ack_reg)
    else $error("pixel byte not committed in ack slot");
  a_cmd_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
    byte_evt && st_reg == MDD_DATA && !dc_reg |=> !mem_we_reg)
    else $error("command byte written to memory");
  a_ptr_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R10]
    mem_we_reg && mem_wx_reg == LAST_X && mem_wy_reg == LAST_Y |-> x_reg == 7'h00 && y_reg == 4'h0)
    else $error("pointer did not wrap after last cell");
  a_load_arbit: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R17]
    $changed(req_tgl_reg) |-> !$past(mem_we_reg) && $past(load_req_reg))
    else $error("line loaded during memory write");
  a_ext_tick: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R7]
    !int_sel_reg && !(osc_f_next && !osc_f_reg) |-> !scan_tick)
    else $error("scan step without external clock edge");
  a_row_range: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R13]
    row_reg <= LAST_ROW)
    else $error("row counter out of range");
  a_frame_flip: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R13]
    scan_tick && row_reg == LAST_ROW |=> row_reg == 7'h00 && pol_reg != $past(pol_reg))
    else $error("frame flip lost at row wrap");
endmodule

// >>> mdd_pkg.sv
// Shared constants and types for the matrix display driver core.
// Assumes a 200 MHz reference clock and a 65 x 102 pixel panel.
package mdd_pkg;
  localparam int REF_CLK_HZ = 200_000_000;
  localparam int REF_CLK_NS = 1_000_000_000 / REF_CLK_HZ;
  // Nominal on-chip oscillator rate
  localparam int INT_OSC_HZ = 34_000;
  localparam int OSC_DIV_CYC = REF_CLK_HZ / INT_OSC_HZ;
  // Osc pin high this long means the on-chip oscillator is selected
  localparam int OSC_HOLD_NS = 100_000;
  localparam int OSC_HOLD_CYC = (OSC_HOLD_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int N_COLS = 102;
  localparam int N_ROWS = 65;
  localparam int N_BANKS = 9;
  localparam logic [6:0] LAST_X = 7'h65;
  localparam logic [3:0] LAST_Y = 4'h8;
  localparam logic [6:0] LAST_ROW = 7'h40;
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1e;
  localparam int CTRL_CO_BIT = 7;
  localparam int CTRL_DC_BIT = 6;
  localparam logic [7:0] CMD_FUNC_MASK = 8'hf8;
  localparam logic [7:0] CMD_FUNC_VAL = 8'h20;
  localparam int FUNC_V_BIT = 1;
  localparam logic [7:0] CMD_SETY_MASK = 8'hf0;
  localparam logic [7:0] CMD_SETY_VAL = 8'h40;
  localparam int CMD_SETX_BIT = 7;
  localparam logic [6:0] X_RST = 7'h00;
  localparam logic [3:0] Y_RST = 4'h0;
  localparam logic V_RST = 1'b0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [4:0] {
    MDD_IDLE = 5'h01,
    MDD_ADDR = 5'h02,
    MDD_CTRL = 5'h04,
    MDD_DATA = 5'h08,
    MDD_SKIP = 5'h10
  } mdd_i2c_e;
endpackage

// >>> mdd_panel_out.sv
// Row and column output stage on the panel clock.
// Assumes line data is held stable by the sender while a toggle request is open.
`timescale 1ns/10ps
module mdd_panel_out (
  input wire logic panel_clk,
  input wire logic rst_b,
  input wire logic req_tgl,
  input wire logic [mdd_pkg::N_COLS-1:0] line_bits,
  input wire logic [6:0] line_row,
  input wire logic line_pol,
  output logic ack_tgl,
  output logic [mdd_pkg::N_COLS-1:0] col_drive,
  output logic [mdd_pkg::N_ROWS-1:0] row_drive,
  output logic row_pol
);
  import mdd_pkg::*;
  logic [1:0] rst_s_reg;
  logic [2:0] req_s_reg;
  logic req_f_reg, req_f_next;
  logic [N_COLS-1:0] col_next;
  logic [N_ROWS-1:0] row_next;
  logic pol_next;
  logic prst_b;

  // Reset enters this domain through two stages
  always_ff @(posedge panel_clk) begin
    rst_s_reg <= {rst_s_reg[0], rst_b};
  end
  assign prst_b = rst_s_reg[1];

  always_comb begin
    req_f_next = (req_s_reg[1] == req_s_reg[2]) ? req_s_reg[2] : req_f_reg;
    col_next = col_drive;
    row_next = row_drive;
    pol_next = row_pol;
    if (req_f_next != req_f_reg) begin
      // Column bias follows pixel data, inverted on odd frames [R13]
      col_next = line_bits ^ {N_COLS{line_pol}};
      for (int r = 0; r < N_ROWS; r++) begin
        row_next[r] = (line_row == 7'(r));
      end
      pol_next = line_pol;
    end
  end

  always_ff @(posedge panel_clk) begin
    if (!prst_b) begin
      req_s_reg <= 3'h0;
      req_f_reg <= 1'b0;
      ack_tgl <= 1'b0;
      col_drive <= '0;
      row_drive <= '0;
      row_pol <= 1'b0;
    end else begin
      req_s_reg <= {req_s_reg[1:0], req_tgl};
      req_f_reg <= req_f_next;
      ack_tgl <= req_f_next;
      col_drive <= col_next;
      row_drive <= row_next;
      row_pol <= pol_next;
    end
  end

  a_one_row: assert property (@(posedge panel_clk) disable iff (!prst_b) // [R13]
    $changed(row_drive) |-> $onehot(row_drive))
    else $error("row drive not one-hot after update");
endmodule

// >>> mdd_i2c_master.sv
// Serial bus master model driving the core's clock and data pins and reading its split ack pins.
// Assumes ref_clk pacing; the data wire has a pull-up and the ack pin pulls it low.
`timescale 1ns/10ps
module mdd_i2c_master #(
  parameter int HP = 20
) (
  input wire logic ref_clk,
  input wire logic ack_output_line,
  input wire logic ack_output_oe,
  output logic scl_in,
  output wire logic serial_data_input
);
  logic drive_low;
  // Wired data line: either party may pull it low
  assign serial_data_input = !(drive_low || (ack_output_oe && !ack_output_line));
  initial begin
    scl_in = 1'b1;
    drive_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus_start();
    drive_low <= 1'b1;
    tick(HP);
    scl_in <= 1'b0;
    tick(8);
  endtask
  // Data only moves with the clock low, well after the slave's ack drops
  task automatic clk_bit(input logic low, output logic seen);
    drive_low <= low;
    tick(HP);
    scl_in <= 1'b1;
    tick(HP);
    seen = serial_data_input;
    scl_in <= 1'b0;
    tick(8);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) clk_bit(!b[i], seen);
    // Ack is reported, never required, so an unwired ack pin is tolerated
    clk_bit(1'b0, seen);
    ack = !seen;
  endtask
  task automatic bus_stop();
    drive_low <= 1'b1;
    tick(HP);
    scl_in <= 1'b1;
    tick(HP);
    drive_low <= 1'b0;
    tick(HP);
  endtask
endmodule

// >>> mdd_core_bench.sv
// Self-checking bench for the matrix display driver core.
// Assumes the serial master model beside it and a free-running panel clock.
`timescale 1ns/10ps
module mdd_core_bench;
  import mdd_pkg::*;
  localparam int DIV = 150;
  localparam int HOLD = 50;
  logic ref_clk = 1'b0;
  logic panel_clk = 1'b0;
  logic rst_b, addr_select_pin, osc_pin, scl_in, serial_data_input, ack_output_line, ack_output_oe, bias_polarity;
  logic [N_COLS-1:0] column_out;
  logic [N_ROWS-1:0] row_out;
  logic [7:0] exp_mem [0:8][0:N_COLS-1];
  logic [6:0] x_ptr;
  logic [3:0] y_ptr;
  logic v_mode;
  logic [31:0] lfsr = 32'ha1eba630;
  logic [7:0] cmds [6] = '{8'h20, 8'h04, 8'hff, 8'h4f, 8'he4, 8'h43};
  logic [7:0] vcmd [3] = '{8'h22, 8'h85, 8'h47};
  int failures = 0;
  int checks = 0;

  mdd_core #(.OSC_DIV(DIV), .OSC_HOLD(HOLD)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .panel_clk(panel_clk), .scl_in(scl_in),
    .serial_data_input(serial_data_input), .addr_select_pin(addr_select_pin), .osc_pin(osc_pin),
    .ack_output_line(ack_output_line), .ack_output_oe(ack_output_oe), .column_out(column_out),
    .row_out(row_out), .bias_polarity(bias_polarity)
  );
  mdd_i2c_master mst (
    .ref_clk(ref_clk), .ack_output_line(ack_output_line), .ack_output_oe(ack_output_oe),
    .scl_in(scl_in), .serial_data_input(serial_data_input)
  );

  initial forever #2.5 ref_clk = ~ref_clk;
  // Odd offset keeps the panel clock out of phase with ref_clk
  initial begin
    #13;
    forever #40 panel_clk = ~panel_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic exp_pix(input int r, input int c);
    return exp_mem[r / 8][c][r % 8];
  endfunction
  function automatic int row_idx(input logic [N_ROWS-1:0] v);
    for (int i = 0; i < N_ROWS; i++) if (v[i] === 1'b1) return i;
    return -1;
  endfunction

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (100) @(posedge ref_clk);
    check("oe", ack_output_oe, 1'b0);
    check("ack line", ack_output_line, 1'b0);
    check("rows", row_out, '0);
    check("cols", column_out, '0);
    check("pol", bias_polarity, 1'b0);
    x_ptr = X_RST;
    y_ptr = Y_RST;
    v_mode = V_RST;
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  // Kind 0 address or control, 1 command, 2 pixel data
  task automatic tx(input logic [7:0] b, input int kind);
    logic ack;
    mst.send_byte(b, ack);
    check("ack", ack, 1'b1);
    if (kind == 1) begin
      if (b[CMD_SETX_BIT]) begin
        if (b[6:0] <= LAST_X) x_ptr = b[6:0];
      end else if ((b & CMD_SETY_MASK) == CMD_SETY_VAL) begin
        if (b[3:0] <= LAST_Y) y_ptr = b[3:0];
      end else if ((b & CMD_FUNC_MASK) == CMD_FUNC_VAL) begin
        v_mode = b[FUNC_V_BIT];
      end
    end else if (kind == 2) begin
      // Last bank keeps only bit zero
      exp_mem[y_ptr][x_ptr] = (y_ptr == LAST_Y) ? {7'hx, b[0]} : b;
      if (v_mode) begin
        y_ptr = (y_ptr == LAST_Y) ? 4'h0 : y_ptr + 4'h1;
        if (y_ptr == 4'h0) x_ptr = (x_ptr == LAST_X) ? 7'h00 : x_ptr + 7'h01;
      end else begin
        x_ptr = (x_ptr == LAST_X) ? 7'h00 : x_ptr + 7'h01;
        if (x_ptr == 7'h00) y_ptr = (y_ptr == LAST_Y) ? 4'h0 : y_ptr + 4'h1;
      end
    end
  endtask

  task automatic scan_check();
    int n;
    for (int r = 0; r < N_ROWS; r++) begin
      n = 0;
      while (row_out !== (65'h1 << r) && n < 20000) begin
        @(posedge ref_clk);
        n++;
      end
      @(negedge panel_clk);
      check("row", row_out, 65'h1 << r);
      for (int c = 0; c < N_COLS; c++)
        if (exp_pix(r, c) !== 1'bx) check("pixel", column_out[c] ^ bias_polarity, exp_pix(r, c));
    end
  endtask

  initial begin
    repeat (95000) @(posedge ref_clk);
    failures++;
    end_sim();
  end

  initial begin
    logic [7:0] a;
    logic ack;
    int r0;
    rst_b = 1'b0;
    addr_select_pin = 1'b0;
    osc_pin = 1'b1;
    do_reset();
    // Both strap levels, both address bits, both directions, then a random stranger
    for (int s = 0; s < 9; s++) begin
      @(posedge ref_clk);
      addr_select_pin <= s[2];
      repeat (10) @(posedge ref_clk);
      lfsr = lfsr_next(lfsr);
      a = (s == 8) ? {(lfsr[6:1] == SLAVE_ADDR_HI) ? 6'h00 : lfsr[6:1], lfsr[0], 1'b0} : {SLAVE_ADDR_HI, s[0], s[1]};
      mst.bus_start();
      mst.send_byte(a, ack);
      check("addr ack", ack, s < 8 && s[0] == s[2] && !s[1]);
      mst.bus_stop();
    end
    // Command list includes a stage-count-zero style byte the core ignores
    mst.bus_start();
    tx(8'h78, 0);
    tx(8'h00, 0);
    foreach (cmds[i]) tx(cmds[i], 1);
    mst.bus_stop();
    // Starts at X 100 so the burst wraps into the next bank
    mst.bus_start();
    r0 = row_idx(row_out);
    tx(8'h78, 0);
    tx(8'h40, 0);
    repeat (10) begin
      lfsr = lfsr_next(lfsr);
      tx(lfsr[7:0], 2);
    end
    check("scan moving", row_idx(row_out) != r0, 1'b1);
    mst.bus_stop();
    mst.bus_start();
    tx(8'h78, 0);
    foreach (vcmd[i]) begin
      tx(8'h80, 0);
      tx(vcmd[i], 1);
    end
    tx(8'h40, 0);
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      tx(lfsr[7:0], 2);
    end
    mst.bus_stop();
    // Last cell, so both pointers wrap together
    mst.bus_start();
    tx(8'h78, 0);
    tx(8'h80, 0);
    tx(8'he5, 1);
    tx(8'h80, 0);
    tx(8'h48, 1);
    tx(8'h40, 0);
    lfsr = lfsr_next(lfsr);
    tx(lfsr[7:0], 2);
    mst.bus_stop();
    scan_check();
    do_reset();
    scan_check();
    @(posedge ref_clk);
    osc_pin <= 1'b0;
    repeat (600) @(posedge ref_clk);
    r0 = row_idx(row_out);
    repeat (1000) @(posedge ref_clk);
    check("osc low", row_idx(row_out), r0);
    // Pulses stay shorter than the hold that selects the internal source
    repeat (3) begin
      osc_pin <= 1'b1;
      repeat (20) @(posedge ref_clk);
      osc_pin <= 1'b0;
      repeat (300) @(posedge ref_clk);
    end
    check("ext steps", row_idx(row_out), (r0 + 3) % N_ROWS);
    osc_pin <= 1'b1;
    end_sim();
  end
endmodule
